// ===== src/adc_four_wire_daisy_serial_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_port_cfg.svh"
module adc_four_wire_daisy_serial_port (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // link pins from the host
    input wire logic i_conversion_start,
    input wire logic i_serial_in_select,
    input wire logic i_sck,
    // serial output pin
    output logic o_serial_out,
    output logic o_serial_out_oe,
    // converter core
    input wire logic [`RESULT_BITS-1:0] i_result,
    input wire logic i_overvoltage_clamp_flag_n,
    input wire logic i_span_comp,
    input wire logic i_high_z,
    input wire logic i_turbo,
    input wire logic i_status_en,
    // state and register writes
    output logic o_converting,
    output logic o_daisy,
    output logic o_wr_strobe,
    output logic [7:0] o_wr_cmd,
    output logic [7:0] o_wr_data
);
    adc_port_pkg::pins_t s1_q;
    adc_port_pkg::pins_t s2_q;
    adc_port_pkg::pins_t s3_q;
    adc_port_pkg::state_t state_q;
    logic conv_rise;
    logic conv_fall;
    logic sel_rise;
    logic sel_fall;
    logic sck_rise;
    logic sck_fall;
    logic [`CONV_CNT_W-1:0] conv_cnt_q;
    logic conv_done;
    logic daisy_q;
    logic busy_q;
    logic first_q;
    logic stat_q;
    logic in_bit_q;
    logic [`FRAME_MSB:0] sh_q;
    logic [`FRAME_MSB:0] sh_next;
    logic [`CNT_W-1:0] cnt_q;
    logic [`CNT_W-1:0] cnt_inc;
    logic [`CNT_W-1:0] cnt_end;
    logic [`WR_BITS-1:0] wr_sh_q;
    logic [`CNT_W-1:0] wr_cnt_q;
    logic dout_d;
    logic oe_d;
    adc_port_pkg::status_t stat_word;

    // two flops for the pins, a third only for edge finding
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= '{conv: i_conversion_start, sel: i_serial_in_select,
                      sck: i_sck};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign conv_rise = s2_q.conv & ~s3_q.conv;
    assign conv_fall = ~s2_q.conv & s3_q.conv;
    assign sel_rise = s2_q.sel & ~s3_q.sel;
    assign sel_fall = ~s2_q.sel & s3_q.sel;
    assign sck_rise = s2_q.sck & ~s3_q.sck;
    assign sck_fall = ~s2_q.sck & s3_q.sck;

    // turbo only reports in status; daisy sequencing never reads it
    assign stat_word = '{ovr_clamp_n: i_overvoltage_clamp_flag_n,
                         span_comp: i_span_comp, high_z: i_high_z,
                         turbo: i_turbo, rsvd: 2'h0};

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            conv_cnt_q <= '0;
        end else if (state_q == adc_port_pkg::ST_IDLE && conv_rise) begin
            conv_cnt_q <= `CONV_CNT_W'(`CONV_CYCLES - 1);
        end else if (conv_cnt_q != '0) begin
            conv_cnt_q <= conv_cnt_q - `CONV_CNT_W'(1);
        end
    end

    assign conv_done = (state_q == adc_port_pkg::ST_CONV) &&
                       (conv_cnt_q == '0);

    // daisy shifting: the upstream bit lands right behind the frame end
    always_comb begin
        sh_next = {sh_q[`FRAME_MSB-1:0], in_bit_q};
        if (!stat_q) begin
            sh_next[`STATUS_BITS] = in_bit_q;
        end
    end

    assign cnt_inc = cnt_q + `CNT_W'(1);
    // busy frames carry one extra leading fall before the msb
    assign cnt_end = (stat_q ? `CNT_W'(`FRAME_BITS) : `CNT_W'(`RESULT_BITS))
                     + {{(`CNT_W-1){1'b0}}, busy_q};

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            in_bit_q <= 1'b0;
        end else if (sck_rise) begin
            in_bit_q <= s2_q.sel;
        end
    end

    // main sequencing
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= adc_port_pkg::ST_IDLE;
            daisy_q <= 1'b0;
            busy_q <= 1'b0;
            first_q <= 1'b0;
            stat_q <= 1'b0;
            sh_q <= '0;
            cnt_q <= '0;
        end else begin
            unique case (state_q)
                adc_port_pkg::ST_IDLE: begin
                    if (conv_rise) begin
                        state_q <= adc_port_pkg::ST_CONV;
                        daisy_q <= ~s2_q.sel & ~s2_q.sck;
                        busy_q <= 1'b0;
                    end
                end
                adc_port_pkg::ST_CONV: begin
                    if (conv_done) begin
                        sh_q <= {i_result, stat_word};
                        stat_q <= i_status_en;
                        cnt_q <= '0;
                        if (daisy_q) begin
                            state_q <= adc_port_pkg::ST_DAISY;
                        end else if (!s2_q.sel) begin
                            state_q <= adc_port_pkg::ST_SHIFT;
                            busy_q <= 1'b1;
                            first_q <= 1'b1;
                        end else begin
                            state_q <= adc_port_pkg::ST_WAIT;
                        end
                    end
                end
                adc_port_pkg::ST_WAIT: begin
                    if (!s2_q.conv) begin
                        state_q <= adc_port_pkg::ST_IDLE;
                    end else if (sel_fall) begin
                        state_q <= adc_port_pkg::ST_SHIFT;
                        first_q <= 1'b0;
                    end
                end
                adc_port_pkg::ST_SHIFT: begin
                    if (!s2_q.conv || sel_rise) begin
                        state_q <= adc_port_pkg::ST_IDLE;
                    end else if (sck_fall) begin
                        cnt_q <= cnt_inc;
                        if (cnt_inc == cnt_end) begin
                            state_q <= adc_port_pkg::ST_IDLE;
                        end else if (first_q) begin
                            first_q <= 1'b0;
                        end else begin
                            sh_q <= {sh_q[`FRAME_MSB-1:0], 1'b0};
                        end
                    end
                end
                adc_port_pkg::ST_DAISY: begin
                    if (conv_fall) begin
                        state_q <= adc_port_pkg::ST_IDLE;
                    end else if (sck_fall) begin
                        sh_q <= sh_next;
                    end
                end
            endcase
        end
    end

    // register write capture while conversion start stays low
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_sh_q <= '0;
            wr_cnt_q <= '0;
            o_wr_strobe <= 1'b0;
            o_wr_cmd <= 8'h00;
            o_wr_data <= 8'h00;
        end else begin
            o_wr_strobe <= 1'b0;
            if (state_q == adc_port_pkg::ST_IDLE && !s2_q.conv) begin
                if (sck_rise) begin
                    wr_sh_q <= {wr_sh_q[`WR_BITS-2:0], s2_q.sel};
                    if (wr_cnt_q != `CNT_W'(`WR_BITS)) begin
                        wr_cnt_q <= wr_cnt_q + `CNT_W'(1);
                    end
                end
            end else if (conv_rise && wr_cnt_q == `CNT_W'(`WR_BITS)) begin
                // last sixteen bits shifted in form command then data
                o_wr_strobe <= 1'b1;
                o_wr_cmd <= wr_sh_q[`WR_BITS-1:8];
                o_wr_data <= wr_sh_q[7:0];
                wr_cnt_q <= '0;
            end else if (s2_q.conv) begin
                wr_cnt_q <= '0;
            end
        end
    end

    // output pin, no register readback path exists in daisy mode
    always_comb begin
        dout_d = 1'b0;
        oe_d = 1'b0;
        unique case (state_q)
            adc_port_pkg::ST_IDLE: begin
                oe_d = ~s2_q.sel & ~s2_q.conv;
            end
            adc_port_pkg::ST_CONV: begin
                oe_d = 1'b0;
            end
            adc_port_pkg::ST_WAIT: begin
                oe_d = 1'b0;
            end
            adc_port_pkg::ST_SHIFT: begin
                oe_d = 1'b1;
                dout_d = first_q ? 1'b0 : sh_q[`FRAME_MSB];
            end
            adc_port_pkg::ST_DAISY: begin
                oe_d = 1'b1;
                dout_d = sh_q[`FRAME_MSB];
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_serial_out <= 1'b0;
            o_serial_out_oe <= 1'b0;
            o_converting <= 1'b0;
            o_daisy <= 1'b0;
        end else begin
            o_serial_out <= dout_d;
            o_serial_out_oe <= oe_d;
            o_converting <= (state_q == adc_port_pkg::ST_CONV);
            o_daisy <= daisy_q;
        end
    end
endmodule : adc_four_wire_daisy_serial_port
`default_nettype wire

// ===== src/adc_port_cfg.svh
// Summary of operation
// - select high at start rise: convert, chip-select mode, float output.
// - select and conversion start both low: output driven low.
// - no busy: after conversion, select falling puts result msb on output.
// - later result bits follow successive sck falls, valid on both edges.
// - no busy: output floats at 18th sck fall (24th with status on) or select rise, first wins.
// - busy: output goes from float to driven low when conversion ends.
// - busy: msb first on sck falls; float at 19th fall (25th with status on) or select rise.
// - start rise with sck and select low: convert, daisy mode, busy off.
// - daisy: msb driven at conversion end, rest shifted on sck falls.
// - daisy: select sampled on sck rise feeds shift register behind result.
// - registers are not readable in daisy mode; status bits show setup.
// - turbo is not combined with daisy-chain operation.
// - status word: overvoltage, span, high-z, turbo, two reserved bits.
`ifndef ADC_PORT_CFG_SVH
`define ADC_PORT_CFG_SVH
`define RESULT_BITS 18
`define STATUS_BITS 6
`define FRAME_BITS 24
`define FRAME_MSB 23
`define CNT_W 5
`define WR_BITS 16
`define CLK_PERIOD_NS 40
`define CONV_TIME_NS 320
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CNT_W 4
`endif

// ===== src/adc_port_pkg.sv
package adc_port_pkg;
    typedef struct packed {
        logic ovr_clamp_n;
        logic span_comp;
        logic high_z;
        logic turbo;
        logic [1:0] rsvd;
    } status_t;
    typedef struct packed {
        logic conv;
        logic sel;
        logic sck;
    } pins_t;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CONV,
        ST_WAIT,
        ST_SHIFT,
        ST_DAISY
    } state_t;
endpackage : adc_port_pkg

// ===== verif/adc_port_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_port_cfg.svh"
module adc_port_chk (
    // clock, reset and pins
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_conversion_start,
    input wire logic i_serial_in_select,
    input wire logic i_sck,
    input wire logic [`RESULT_BITS-1:0] i_result,
    // observed outputs
    input wire logic o_serial_out,
    input wire logic o_serial_out_oe,
    input wire logic o_converting,
    input wire logic o_daisy,
    input wire logic o_wr_strobe,
    input wire logic [7:0] o_wr_cmd,
    input wire logic [7:0] o_wr_data
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);
    // six cycles covers the pin synchronisers
    a_idle_low: assert property (
        (!i_conversion_start && !i_serial_in_select) [*6]
        |-> o_serial_out_oe && !o_serial_out) else $error("idle not low");
    a_conv_float: assert property (
        $rose(o_converting) && !o_daisy |=> !o_serial_out_oe [*7])
        else $error("driven while converting");
    a_conv_len: assert property (
        $rose(o_converting) |-> o_converting [*8] ##1 !o_converting)
        else $error("conversion length");
    a_busy_low: assert property (
        $fell(o_converting) && !o_daisy && !i_serial_in_select &&
        !$past(i_serial_in_select, 4)
        |-> ##[0:1] o_serial_out_oe && !o_serial_out)
        else $error("no busy low");
    a_wait_float: assert property (
        $fell(o_converting) && !o_daisy && i_serial_in_select &&
        $past(i_serial_in_select, 4) |-> !o_serial_out_oe [*3])
        else $error("driven before select");
    a_daisy_msb: assert property (
        $fell(o_converting) && o_daisy |-> ##[0:1] o_serial_out_oe &&
        o_serial_out == i_result[`RESULT_BITS-1]) else $error("daisy msb");
    a_select_float: assert property (
        i_serial_in_select [*6] ##0 (!o_daisy && !o_converting)
        |-> !o_serial_out_oe) else $error("driven while deselected");
    a_bits_hold: assert property (
        $rose(i_sck) && !o_converting |=>
        ($stable(o_serial_out) && $stable(o_serial_out_oe)) [*5])
        else $error("data moved near rising clock");
    c_daisy: cover property ($fell(o_converting) && o_daisy);
    c_busy: cover property ($fell(o_converting) && !i_serial_in_select);
    c_write: cover property (o_wr_strobe);
endmodule : adc_port_chk
bind adc_four_wire_daisy_serial_port adc_port_chk u_chk (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_sck(i_sck), .i_result(i_result),
    .i_conversion_start(i_conversion_start),
    .i_serial_in_select(i_serial_in_select),
    .o_serial_out(o_serial_out), .o_serial_out_oe(o_serial_out_oe),
    .o_converting(o_converting), .o_daisy(o_daisy),
    .o_wr_strobe(o_wr_strobe), .o_wr_cmd(o_wr_cmd), .o_wr_data(o_wr_data));
`default_nettype wire

// ===== verif/adc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module adc_host_model (
    // clock
    input wire logic i_clk,
    // pins towards the converter
    output logic o_conversion_start,
    output logic o_serial_in_select,
    output logic o_sck
);
    initial begin
        o_conversion_start = 1'b0;
        o_serial_in_select = 1'b0;
        o_sck = 1'b0;
    end
    // start and select levels held for w clocks
    task automatic pins(input logic c, input logic s, input int w);
        @(negedge i_clk);
        o_conversion_start <= c;
        o_serial_in_select <= s;
        repeat (w) @(negedge i_clk);
    endtask : pins
    // sck idles low between frames; 3 high + 4 low clk alone, rd's note adds a high clk: 4 + 4 gives 320 ns
    task automatic rise();
        @(negedge i_clk);
        o_sck <= 1'b1;
        repeat (2) @(negedge i_clk);
    endtask : rise
    // data changes on the fall so it is settled at the next rise
    task automatic fall(input logic d);
        @(negedge i_clk);
        o_sck <= 1'b0;
        o_serial_in_select <= d;
        repeat (3) @(negedge i_clk);
    endtask : fall
endmodule : adc_host_model
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic i_clk, i_rst_b, dout, oe, conv, daisy, wr_stb, look, stat_en;
    wire logic start_pin, sel_pin, sck;
    logic [7:0] wr_cmd, wr_dat;
    logic [17:0] res;
    logic [5:0] stat;
    logic [35:0] dv;
    logic [15:0] wv;
    logic [1:0] pin_q[$];
    logic [15:0] wr_q[$];
    int failures, total_checks, cycles;
    adc_four_wire_daisy_serial_port DUT (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_conversion_start(start_pin),
        .i_serial_in_select(sel_pin), .i_sck(sck), .o_serial_out(dout),
        .o_serial_out_oe(oe), .i_result(res),
        .i_overvoltage_clamp_flag_n(stat[5]), .i_span_comp(stat[4]),
        .i_high_z(stat[3]), .i_turbo(stat[2]), .i_status_en(stat_en),
        .o_converting(conv), .o_daisy(daisy), .o_wr_strobe(wr_stb),
        .o_wr_cmd(wr_cmd), .o_wr_data(wr_dat));
    adc_host_model host (.i_clk(i_clk), .o_conversion_start(start_pin),
        .o_serial_in_select(sel_pin), .o_sck(sck));
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    task automatic stop_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask : check
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            stop_test();
        end
    end
    always @(negedge i_clk) begin
        if (look)
            check({oe, oe & dout}, pin_q.pop_front());
        if (wr_stb === 1'b1)
            check({wr_cmd, wr_dat}, wr_q.pop_front());
    end
    task automatic note(input logic [1:0] e);
        pin_q.push_back(e);
        look <= 1'b1;
        @(negedge i_clk);
        look <= 1'b0;
    endtask : note
    task automatic rd(input logic d, input logic [1:0] e);
        host.rise();
        note(e);
        host.fall(d);
    endtask : rd
    task automatic wait_conv();
        repeat (20) if (conv !== 1'b1) @(negedge i_clk);
        repeat (20) if (conv !== 1'b0) @(negedge i_clk);
    endtask : wait_conv
    // b busy slots before the frame, n frame bits, then one float slot
    task automatic readout(input int b, input int n);
        logic [23:0] fr;
        fr = {res, stat_en ? stat : 6'h00};
        for (int i = 0; i <= n + b; i++) begin
            if (i < b) rd(1'b0, 2'b10);
            else if (i - b < n)
                rd(1'b0, {1'b1, fr[23 - i + b]});
            else rd(1'b0, 2'b00);
        end
    endtask : readout
    initial begin
        void'($urandom(32'he6d6));
        {i_rst_b, look, stat_en, res, stat} = '0;
        {failures, total_checks, cycles} = '0;
        repeat (20) @(negedge i_clk);
        i_rst_b = 1'b1;
        host.pins(1'b0, 1'b0, 6);
        note(2'b10);
        wv = 16'($urandom);
        wr_q.push_back(wv);
        host.fall(wv[15]);
        for (int i = 14; i >= -1; i--) begin
            host.rise();
            host.fall(i < 0 ? 1'b1 : wv[i]);
        end
        res = 18'($urandom);
        stat = 6'($urandom) & 6'h3c;
        stat_en = 1'b1;
        host.pins(1'b1, 1'b1, 6);
        note(2'b00);
        check(16'(conv), 16'h0001);
        check(16'(daisy), 16'h0000);
        wait_conv();
        repeat (6) @(negedge i_clk);
        note(2'b00);
        host.pins(1'b1, 1'b0, 6);
        readout(0, 24);
        res = 18'($urandom);
        stat_en = 1'b0;
        host.pins(1'b0, 1'b1, 6);
        host.pins(1'b1, 1'b1, 2);
        host.pins(1'b1, 1'b0, 6);
        wait_conv();
        readout(1, 18);
        res = 18'($urandom);
        dv = 36'({$urandom, $urandom});
        stat[2] = 1'b0;
        host.pins(1'b0, 1'b0, 6);
        host.pins(1'b1, 1'b0, 6);
        wait_conv();
        check(16'(daisy), 16'h0001);
        for (int i = 0; i < 36; i++)
            rd(dv[i], {1'b1, i < 18 ? res[17 - i] :
                (i == 18 ? 1'b0 : dv[i - 19])});
        host.pins(1'b0, 1'b0, 6);
        note(2'b10);
        stop_test();
    end
endmodule : tb
`default_nettype wire
